// File: rtl/adc_gain_alc_mute_ctrl.v
// Gain path controller: analog gain stage, digital attenuator, level
// control, soft mute, three-wire write port and an Avalon-MM slave.
// Assumes analog detectors and pins arrive asynchronously to clk_i.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`include "adc_gain_consts.vh"

module adc_gain_alc_mute_ctrl (
	// Clock and reset
	input  wire        clk_i,
	input  wire        srst_i,
	// Avalon-MM slave
	input  wire [4:0]  address_i,
	input  wire        read_i,
	input  wire        write_i,
	input  wire [3:0]  byteenable_i,
	input  wire [31:0] writedata_i,
	output reg  [31:0] readdata_o,
	output wire        waitrequest_o,
	// Device pins
	input  wire        word_clock_i,
	input  wire        chip_select_n_i,
	input  wire        control_clock_i,
	input  wire        control_data_in_i,
	input  wire        power_down_n_i,
	input  wire        alc_pin_i,
	input  wire        soft_mute_pin_i,
	// Analog detectors, per channel except the single impulse input
	input  wire [1:0]  zero_cross_i,
	input  wire [1:0]  over_limit_i,
	input  wire [1:0]  over_reset_i,
	input  wire        impulse_i,
	// Gain path controls
	output reg  [4:0]  gain_left_o,
	output reg  [4:0]  gain_right_o,
	output reg  [12:0] attenuation_o,
	output wire        limiter_threshold_o,
	output wire [2:0]  input_select_o,
	output wire [2:0]  clock_format_o,
	output wire        power_enable_o,
	output wire        alc_active_o
);

	localparam SYNC_W = 12;
	localparam ST_IDLE    = 2'h0;
	localparam ST_LIMIT   = 2'h1;
	localparam ST_RECOVER = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers
	wire [SYNC_W-1:0] async_in;
	reg  [SYNC_W-1:0] meta_q;
	reg  [SYNC_W-1:0] sync_q;
	// Impulse detector has its own pair below, so it stays out of this word
	assign async_in = {over_reset_i, over_limit_i, zero_cross_i, soft_mute_pin_i,
		alc_pin_i, power_down_n_i, control_data_in_i, control_clock_i, chip_select_n_i};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
			always @(posedge clk_i) begin
				meta_q[gi] <= async_in[gi];
				sync_q[gi] <= meta_q[gi];
			end
		end
	endgenerate

	wire       cs_n_s   = sync_q[0];
	wire       control_clock_s   = sync_q[1];
	wire       control_data_in_s   = sync_q[2];
	wire       pdn_n_s  = sync_q[3];
	wire       alc_pin  = sync_q[4];
	wire       mute_pin = sync_q[5];
	wire [1:0] zc_s     = sync_q[7:6];
	wire [1:0] over_s   = sync_q[9:8];
	wire [1:0] orst_s   = sync_q[11:10];
	wire       imp_s;
	reg        imp_meta_q;
	reg        imp_q;
	always @(posedge clk_i) begin
		imp_meta_q <= impulse_i;
		imp_q      <= imp_meta_q;
	end
	assign imp_s = imp_q;

	// Power-down pin clears all but the bus handshake and read data alongside the bus reset
	wire rst = srst_i | ~pdn_n_s;

	////////////////////////////////////////////////////////////////////////
	// Sample tick from the word clock
	reg wclk_meta_q;
	reg wclk_q;
	reg wclk_d1_q;
	always @(posedge clk_i) begin
		wclk_meta_q <= word_clock_i;
		wclk_q      <= wclk_meta_q;
		wclk_d1_q   <= wclk_q;
	end
	wire tick = wclk_q & ~wclk_d1_q;

	////////////////////////////////////////////////////////////////////////
	// Three-wire write port
	reg  [15:0] shift_q;
	reg  [4:0]  bit_cnt_q;
	reg         control_clock_d1_q;
	reg         cs_d1_q;
	wire        control_clock_rise = control_clock_s & ~control_clock_d1_q;
	wire        cs_rise   = cs_n_s & ~cs_d1_q;
	wire        ser_we;
	always @(posedge clk_i) begin
		if (rst) begin
			shift_q   <= 16'h0000;
			bit_cnt_q <= 5'h00;
			control_clock_d1_q <= 1'b1;
			cs_d1_q   <= 1'b1;
		end else begin
			control_clock_d1_q <= control_clock_s;
			cs_d1_q   <= cs_n_s;
			if (cs_n_s) begin
				bit_cnt_q <= 5'h00;
			end else if (control_clock_rise) begin
				shift_q <= {shift_q[14:0], control_data_in_s};
				if (bit_cnt_q != 5'h1F)
					bit_cnt_q <= bit_cnt_q + 5'h01;
			end
		end
	end
	// Extra bits past a frame spoil it rather than shifting the address
	assign ser_we = cs_rise && (bit_cnt_q == `FRAME_BITS) &&
		(shift_q[15:13] == `FRAME_HEADER) && (shift_q[12:11] == 2'h0);
	wire [2:0] ser_idx  = shift_q[10:8];
	wire [7:0] ser_data = shift_q[7:0];

	////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave, one wait state on every access
	reg  ack_q;
	wire req    = read_i | write_i;
	wire mapped = (address_i[4:2] <= 3'h7) || (address_i[4:2] == 3'h0);
	wire [3:0] bus_idx = {1'b0, address_i[4:2]};
	wire bus_we = write_i & ack_q & byteenable_i[0];
	assign waitrequest_o = req & ~ack_q;
	always @(posedge clk_i) begin
		if (srst_i)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Register file; serial write wins over a bus write to the same index
	reg [7:0] regs_q [0:7];
	reg [7:0] last_gain_q [0:1];
	reg [1:0] gain_wr;
	reg [7:0] gain_wdata [0:1];
	integer ri;
	always @* begin
		for (ri = 0; ri < 2; ri = ri + 1) begin
			gain_wr[ri]    = 1'b0;
			gain_wdata[ri] = 8'h00;
			if (bus_we && bus_idx == {1'b0, `REG_GAIN_LEFT} + ri[3:0]) begin
				gain_wr[ri]    = 1'b1;
				gain_wdata[ri] = writedata_i[7:0];
			end
			if (ser_we && ser_idx == `REG_GAIN_LEFT + ri[2:0]) begin
				gain_wr[ri]    = 1'b1;
				gain_wdata[ri] = ser_data;
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst) begin
			regs_q[0] <= `RST_POWER;
			regs_q[1] <= `RST_SELECT;
			regs_q[2] <= `RST_CLOCK_FORMAT;
			regs_q[3] <= `RST_TIMER_SELECT;
			regs_q[4] <= `RST_GAIN;
			regs_q[5] <= `RST_GAIN;
			regs_q[6] <= `RST_ALC_CONTROL;
			regs_q[7] <= `RST_TARGET_LEVEL;
		end else begin
			if (bus_we && bus_idx < `REG_COUNT)
				regs_q[bus_idx[2:0]] <= writedata_i[7:0];
			if (ser_we)
				regs_q[ser_idx] <= ser_data;
		end
	end

	wire [1:0] zc_sel   = regs_q[`REG_TIMER_SELECT][3:2];
	wire [1:0] lim_sel  = regs_q[`REG_TIMER_SELECT][5:4];
	wire [1:0] wait_sel = regs_q[`REG_TIMER_SELECT][1:0];
	wire [7:0] alc_ctl  = regs_q[`REG_ALC_CONTROL];
	wire [4:0] lim_step = {3'h0, alc_ctl[4:3]} + 5'h01;
	wire [4:0] rec_step = {3'h0, alc_ctl[2:1]} + 5'h01;
	wire       fast_imp = alc_ctl[`FLD_FAST_MODE] & imp_s;
	wire       zc_dis   = alc_ctl[`FLD_ZC_DISABLE];
	wire       alc_on   = alc_ctl[`FLD_ALC_ENABLE] | alc_pin;
	wire       mute_req = regs_q[`REG_CLOCK_FORMAT][`FLD_SOFT_MUTE] | mute_pin;

	assign limiter_threshold_o = alc_ctl[`FLD_THRESHOLD];
	assign input_select_o      = regs_q[`REG_SELECT][2:0];
	assign clock_format_o      = regs_q[`REG_CLOCK_FORMAT][3:1];
	assign power_enable_o      = regs_q[`REG_POWER][0];

	reg [12:0] zc_timeout;
	reg [12:0] lim_period;
	reg [12:0] wait_period;
	always @* begin
		case (zc_sel)
		2'h0:    zc_timeout = `ZC_TIMEOUT_0;
		2'h1:    zc_timeout = `ZC_TIMEOUT_1;
		2'h2:    zc_timeout = `ZC_TIMEOUT_2;
		default: zc_timeout = `ZC_TIMEOUT_3;
		endcase
		case (lim_sel)
		2'h0:    lim_period = `LIM_PERIOD_0;
		2'h1:    lim_period = `LIM_PERIOD_1;
		2'h2:    lim_period = `LIM_PERIOD_2;
		default: lim_period = `LIM_PERIOD_3;
		endcase
		case (wait_sel)
		2'h0:    wait_period = `WAIT_PERIOD_0;
		2'h1:    wait_period = `WAIT_PERIOD_1;
		2'h2:    wait_period = `WAIT_PERIOD_2;
		default: wait_period = `WAIT_PERIOD_3;
		endcase
	end

	function [4:0] gain_index;
		input [7:0] word;
		begin
			gain_index = (word[6:0] > {2'h0, `ANALOG_STEPS}) ? `ANALOG_STEPS : word[4:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Level control: common gain, limiter and recovery
	reg [1:0]  alc_st_q;
	reg [4:0]  alc_gain_q;
	reg [12:0] alc_cnt_q;
	reg        alc_on_d1_q;
	wire       any_over  = |over_s;
	wire       any_orst  = |orst_s;
	wire       any_zc    = |zc_s;
	wire [4:0] tgt_index = gain_index(regs_q[`REG_TARGET_LEVEL]);
	// Impulse fast mode halves the period; crossing-disabled limiting keeps its own period
	wire [12:0] lim_base = zc_dis ? lim_period : zc_timeout;
	wire [12:0] lim_eff  = (fast_imp && !zc_dis) ? {1'b0, lim_base[12:1]} : lim_base;
	wire [12:0] wait_eff = fast_imp ? {1'b0, wait_period[12:1]} : wait_period;
	wire        lim_due  = (alc_cnt_q + 13'h0001 >= lim_eff) || (!zc_dis && any_zc);
	assign alc_active_o = (alc_st_q != ST_IDLE);

	always @(posedge clk_i) begin
		if (rst) begin
			alc_st_q    <= ST_IDLE;
			alc_gain_q  <= 5'h00;
			alc_cnt_q   <= 13'h0000;
			alc_on_d1_q <= 1'b0;
		end else begin
			alc_on_d1_q <= alc_on;
			case (alc_st_q)
			ST_IDLE: begin
				if (alc_on) begin
					alc_gain_q <= gain_left_o;
					alc_cnt_q  <= 13'h0000;
					alc_st_q   <= ST_RECOVER;
				end
			end
			ST_LIMIT: begin
				if (!alc_on) begin
					alc_st_q <= ST_IDLE;
				end else if (tick) begin
					if (!any_over) begin
						alc_cnt_q <= 13'h0000;
						alc_st_q  <= ST_RECOVER;
					end else if (lim_due) begin
						alc_cnt_q  <= 13'h0000;
						alc_gain_q <= (alc_gain_q > lim_step) ? alc_gain_q - lim_step : 5'h00;
					end else begin
						alc_cnt_q <= alc_cnt_q + 13'h0001;
					end
				end
			end
			ST_RECOVER: begin
				if (!alc_on) begin
					alc_st_q <= ST_IDLE;
				end else if (any_over) begin
					alc_cnt_q <= 13'h0000;
					alc_st_q  <= ST_LIMIT;
				end else if (tick) begin
					if (any_orst) begin
						alc_cnt_q <= 13'h0000;
					end else if (alc_cnt_q + 13'h0001 >= wait_eff) begin
						alc_cnt_q <= 13'h0000;
						if (alc_gain_q + rec_step < tgt_index)
							alc_gain_q <= alc_gain_q + rec_step;
						else if (alc_gain_q < tgt_index)
							alc_gain_q <= tgt_index;
					end else begin
						alc_cnt_q <= alc_cnt_q + 13'h0001;
					end
				end
			end
			default: alc_st_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-channel analog gain with zero-cross or timeout update
	reg [1:0]  pend_q;
	reg [12:0] zc_cnt_q [0:1];
	wire       alc_off_edge = alc_on_d1_q & ~alc_on;
	wire [4:0] chan_gain [0:1];
	assign chan_gain[0] = gain_left_o;
	assign chan_gain[1] = gain_right_o;

	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
			reg [4:0] gain_q;
			always @(posedge clk_i) begin
				if (rst) begin
					gain_q          <= gain_index(`RST_GAIN);
					pend_q[gi]      <= 1'b0;
					zc_cnt_q[gi]    <= 13'h0000;
					last_gain_q[gi] <= `RST_GAIN;
				end else begin
					if (gain_wr[gi] && gain_wdata[gi][`FLD_ANALOG_HALF])
						last_gain_q[gi] <= gain_wdata[gi];
					// State is still active on the off edge, so the edge must win
					if (alc_off_edge) begin
						pend_q[gi]   <= 1'b1;
						zc_cnt_q[gi] <= 13'h0000;
					end else if (alc_active_o) begin
						gain_q     <= alc_gain_q;
						pend_q[gi] <= 1'b0;
					end else if (gain_wr[gi] && gain_wdata[gi][`FLD_ANALOG_HALF] && !alc_on) begin
						pend_q[gi]   <= 1'b1;
						zc_cnt_q[gi] <= 13'h0000;
					end else if (pend_q[gi] && zc_s[gi]) begin
						gain_q     <= gain_index(last_gain_q[gi]);
						pend_q[gi] <= 1'b0;
					end else if (pend_q[gi] && tick) begin
						if (zc_cnt_q[gi] + 13'h0001 >= zc_timeout) begin
							gain_q     <= gain_index(last_gain_q[gi]);
							pend_q[gi] <= 1'b0;
						end else begin
							zc_cnt_q[gi] <= zc_cnt_q[gi] + 13'h0001;
						end
					end
				end
			end
		end
	endgenerate

	always @* begin
		gain_left_o  = g_chan[0].gain_q;
		gain_right_o = g_chan[1].gain_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Digital attenuator and soft mute share one ramp
	reg  [6:0]  att_set_q;
	wire [12:0] att_fine = {att_set_q, 6'h00} >> (13 - 7 - `ATT_FINE_SHIFT);
	// Mute target zero; release simply retargets, so a half ramp turns back
	wire [12:0] att_tgt  = mute_req ? 13'h0000 : att_fine;
	always @(posedge clk_i) begin
		if (rst) begin
			att_set_q     <= 7'h7F;
			attenuation_o <= 13'h0000;
		end else begin
			if (gain_wr[0] && !gain_wdata[0][`FLD_ANALOG_HALF])
				att_set_q <= gain_wdata[0][6:0];
			else if (gain_wr[1] && !gain_wdata[1][`FLD_ANALOG_HALF])
				att_set_q <= gain_wdata[1][6:0];
			if (tick) begin
				if (attenuation_o + `ATT_RAMP_STEP <= att_tgt)
					attenuation_o <= attenuation_o + `ATT_RAMP_STEP;
				else if (attenuation_o < att_tgt)
					attenuation_o <= att_tgt;
				else if (attenuation_o >= att_tgt + `ATT_RAMP_STEP)
					attenuation_o <= attenuation_o - `ATT_RAMP_STEP;
				else
					attenuation_o <= att_tgt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data is captured in the wait cycle and held for the accepting edge
	always @(posedge clk_i) begin
		if (srst_i) begin
			readdata_o <= 32'h00000000;
		end else if (read_i && !ack_q) begin
			if (bus_idx < `REG_COUNT)
				readdata_o <= {24'h000000, regs_q[bus_idx[2:0]]};
			else if (address_i[4:2] == 3'h0 && !mapped)
				readdata_o <= 32'h00000000;
			else
				readdata_o <= 32'h00000000;
		end
	end

endmodule

// File: rtl/adc_gain_consts.vh
// Constants for the ADC gain, level control and mute controller.
// Assumes inclusion by the controller; timeouts and periods are in sample periods.
`ifndef ADC_GAIN_CONSTS_VH
`define ADC_GAIN_CONSTS_VH

// Register indices; byte address is index times four
`define REG_POWER           3'h0
`define REG_SELECT          3'h1
`define REG_CLOCK_FORMAT    3'h2
`define REG_TIMER_SELECT    3'h3
`define REG_GAIN_LEFT       3'h4
`define REG_GAIN_RIGHT      3'h5
`define REG_ALC_CONTROL     3'h6
`define REG_TARGET_LEVEL    3'h7
`define REG_STATUS_INDEX    4'h8
`define REG_COUNT           4'h8

// Reset values
`define RST_POWER           8'h01
`define RST_SELECT          8'h00
`define RST_CLOCK_FORMAT    8'h00
`define RST_TIMER_SELECT    8'h00
`define RST_GAIN            8'h80
`define RST_ALC_CONTROL     8'h00
`define RST_TARGET_LEVEL    8'h8C

// Field positions
`define FLD_SOFT_MUTE       0
`define FLD_ALC_ENABLE      7
`define FLD_FAST_MODE       6
`define FLD_ZC_DISABLE      5
`define FLD_THRESHOLD       0
`define FLD_ANALOG_HALF     7

// Gain path sizes
`define ANALOG_STEPS        5'h18
`define ATT_FINE_SHIFT      6
`define ATT_RAMP_STEP       13'h0008

// Serial frame
`define FRAME_BITS          5'h10
`define FRAME_HEADER        3'h5

// Zero-cross timeouts in sample periods
`define ZC_TIMEOUT_0        13'h0120
`define ZC_TIMEOUT_1        13'h0480
`define ZC_TIMEOUT_2        13'h0900
`define ZC_TIMEOUT_3        13'h1200

// Limiter step periods in sample periods
`define LIM_PERIOD_0        13'h0010
`define LIM_PERIOD_1        13'h0020
`define LIM_PERIOD_2        13'h0040
`define LIM_PERIOD_3        13'h0080

// Recovery wait periods in sample periods
`define WAIT_PERIOD_0       13'h0180
`define WAIT_PERIOD_1       13'h0300
`define WAIT_PERIOD_2       13'h0600
`define WAIT_PERIOD_3       13'h0C00

`endif

// File: tb/adc_gain_alc_mute_ctrl_bench.sv
// Self-checking bench for the gain, level control and mute controller.
// Assumes the three-wire host model and the bound port checker.
`timescale 1ns/100ps
module adc_gain_alc_mute_ctrl_bench;
logic        clk_i = 1'b0, srst_i = 1'b1, read_i = 1'b0, write_i = 1'b0;
logic        word_clock_i = 1'b0, power_down_n_i = 1'b1, alc_pin_i = 1'b0;
logic        soft_mute_pin_i = 1'b0, impulse_i = 1'b0;
logic [4:0]  address_i = 5'h00;
logic [3:0]  byteenable_i = 4'hF;
logic [31:0] writedata_i = 32'h00000000;
logic [1:0]  zero_cross_i = 2'h0, over_limit_i = 2'h0, over_reset_i = 2'h0, zc_run = 2'h0;
logic [7:0]  rd;
logic [12:0] a;
wire  [31:0] readdata_o;
wire         waitrequest_o, chip_select_n_i, control_clock_i, control_data_in_i;
wire         limiter_threshold_o, power_enable_o, alc_active_o;
wire  [4:0]  gain_left_o, gain_right_o;
wire  [12:0] attenuation_o;
wire  [2:0]  input_select_o, clock_format_o;
integer      mismatches = 0, compares = 0, cycles = 0, i, k, v, l;
logic [7:0]  dflt [0:7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h8C};
logic [15:0] bad [0:2] = '{16'h2104, 16'hA104, 16'hA904};
integer      tmo [0:3] = '{288, 1152, 2304, 4608};

three_wire_host host_u (
	.chip_select_n_o (chip_select_n_i),
	.control_clock_o (control_clock_i),
	.control_data_o  (control_data_in_i)
);
adc_gain_alc_mute_ctrl dut_u (
	.clk_i, .srst_i, .address_i, .read_i, .write_i, .byteenable_i, .writedata_i,
	.readdata_o, .waitrequest_o, .word_clock_i, .chip_select_n_i, .control_clock_i,
	.control_data_in_i, .power_down_n_i, .alc_pin_i, .soft_mute_pin_i, .zero_cross_i,
	.over_limit_i, .over_reset_i, .impulse_i, .gain_left_o, .gain_right_o, .attenuation_o,
	.limiter_threshold_o, .input_select_o, .clock_format_o, .power_enable_o, .alc_active_o
);
////////////////////////////////////////////////////////////////////////////////
always #2 clk_i = ~clk_i;
// Six clk per sample keeps the long timeouts affordable
always #12 word_clock_i = ~word_clock_i;
always @(posedge clk_i) begin
	cycles <= cycles + 1;
	if (cycles % 16 == 0) begin
		zero_cross_i <= zero_cross_i ^ zc_run;
	end
	if (cycles == 90000) begin
		mismatches = mismatches + 1;
		conclude;
	end
end
////////////////////////////////////////////////////////////////////////////////
function [4:0] gain_idx(input logic [7:0] w);
	gain_idx = (w[6:0] > 7'h18) ? 5'h18 : w[4:0];
endfunction
function [12:0] att_level(input logic [7:0] w);
	att_level = {w[6:0], 6'h00};
endfunction
function [12:0] val(input integer sel);
	val = (sel == 0) ? {8'h00, gain_left_o} : (sel == 1) ? {8'h00, gain_right_o} : attenuation_o;
endfunction
function integer pick(input integer c);
	pick = (c + 1 + $urandom % 23) % 25;
endfunction
task check(input logic [31:0] got, input logic [31:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
endtask
task conclude;
	begin
		if (mismatches == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	end
endtask
task wait_samples(input integer n);
	repeat (n * 6) @(posedge clk_i);
endtask
// Bus cycle: request held until waitrequest is seen low
task bus(input logic wr, input logic [2:0] idx, input logic [7:0] d, input logic [3:0] be);
	begin
		address_i <= {idx, 2'h0};
		writedata_i <= {24'h000000, d};
		byteenable_i <= be;
		read_i <= ~wr;
		write_i <= wr;
		@(posedge clk_i);
		while (waitrequest_o !== 1'b0) begin
			@(posedge clk_i);
		end
		rd = readdata_o[7:0];
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clk_i);
	end
endtask
task wait_for(input integer sel, input logic [12:0] exp, input integer lim);
	integer n;
	begin
		n = 0;
		while (val(sel) !== exp && n < lim * 6) begin
			@(posedge clk_i);
			n = n + 1;
		end
		check(val(sel), exp);
	end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	void'($urandom(17777));
	repeat (20) @(posedge clk_i);
	srst_i <= 1'b0;
	@(posedge clk_i);
	for (i = 0; i < 8; i = i + 1) begin
		bus(1'b0, i[2:0], 8'h00, 4'hF);
		check(rd, dflt[i]);
	end
	v = $urandom % 5;
	bus(1'b1, 3'h1, v[7:0], 4'hF);
	check(input_select_o, v[2:0]);
	bus(1'b1, 3'h1, 8'h07, 4'hE);
	check(input_select_o, v[2:0]);
	bus(1'b1, 3'h6, 8'h01, 4'hF);
	check(limiter_threshold_o, 1'b1);
	v = $urandom % 4;
	host_u.send({3'h5, 5'h01, v[7:0]}, 16);
	repeat (10) @(posedge clk_i);
	check(input_select_o, v[2:0]);
	for (k = 0; k < 3; k = k + 1) begin
		host_u.send(bad[k], (k == 1) ? 15 : 16);
		repeat (10) @(posedge clk_i);
		check(input_select_o, v[2:0]);
	end
	power_down_n_i <= 1'b0;
	repeat (10) @(posedge clk_i);
	power_down_n_i <= 1'b1;
	repeat (5) @(posedge clk_i);
	bus(1'b0, 3'h1, 8'h00, 4'hF);
	check(rd, 8'h00);
	check(limiter_threshold_o, 1'b0);
	l = 0;
	for (k = 0; k < 4; k = k + 1) begin
		bus(1'b1, 3'h3, {4'h0, k[1:0], 2'h0}, 4'hF);
		v = pick(l);
		if (k == 0) begin
			bus(1'b1, 3'h5, 8'h80 | v[7:0], 4'hF);
			wait_samples(150);
			v = pick(l);
		end
		bus(1'b1, 3'h5, 8'h80 | v[7:0], 4'hF);
		wait_samples(tmo[k] - 4);
		check(gain_right_o, l[4:0]);
		wait_for(1, gain_idx(8'h80 | v[7:0]), 10);
		l = v;
	end
	v = (l % 24) + 1;
	bus(1'b1, 3'h4, 8'h80 | v[7:0], 4'hF);
	zc_run <= 2'h1;
	wait_for(0, gain_idx(8'h80 | v[7:0]), 20);
	check(gain_right_o, l[4:0]);
	check(attenuation_o, att_level(8'h7F));
	soft_mute_pin_i <= 1'b1;
	wait_for(2, 13'h0000, 1026);
	soft_mute_pin_i <= 1'b0;
	wait_for(2, att_level(8'h7F), 1026);
	bus(1'b1, 3'h2, 8'h0F, 4'hF);
	check(clock_format_o, 3'h7);
	wait_samples(100);
	a = attenuation_o;
	check(a < att_level(8'h7F), 1'b1);
	bus(1'b1, 3'h2, 8'h00, 4'hF);
	check(clock_format_o, 3'h0);
	wait_samples(20);
	check(attenuation_o > a, 1'b1);
	zc_run <= 2'h3;
	alc_pin_i <= 1'b1;
	// Held reset level keeps the recovery wait from ever expiring
	over_reset_i <= 2'h3;
	wait_samples(10);
	check(alc_active_o, 1'b1);
	check(gain_right_o, v[4:0]);
	bus(1'b1, 3'h4, 8'h82, 4'hF);
	wait_samples(30);
	check(gain_left_o, v[4:0]);
	bus(1'b1, 3'h4, 8'h40, 4'hF);
	wait_for(2, att_level(8'h40), 520);
	check(gain_left_o, v[4:0]);
	a = {8'h00, gain_left_o};
	over_limit_i <= 2'h2;
	wait_samples(40);
	check(gain_left_o < a[4:0], 1'b1);
	over_limit_i <= 2'h0;
	over_reset_i <= 2'h0;
	alc_pin_i <= 1'b0;
	wait_for(0, gain_idx(8'h82), 20);
	wait_for(1, l[12:0], 20);
	zc_run <= 2'h0;
	conclude;
end
endmodule

// File: tb/adc_gain_alc_mute_ctrl_properties.sv
// Port-level checks for the gain, level control and mute controller.
// Assumes binding to its top module; everything runs on clk_i.
`timescale 1ns/100ps
module adc_gain_props (
	// Clock and reset
	input wire        clk_i,
	input wire        srst_i,
	// Bus and pins
	input wire        read_i,
	input wire        write_i,
	input wire        waitrequest_o,
	input wire        chip_select_n_i,
	input wire        power_down_n_i,
	input wire        alc_pin_i,
	input wire        soft_mute_pin_i,
	// Gain path
	input wire [4:0]  gain_left_o,
	input wire [4:0]  gain_right_o,
	input wire [12:0] attenuation_o,
	input wire [2:0]  input_select_o,
	input wire        power_enable_o,
	input wire        alc_active_o
);
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk_i);
endclocking
// Power-down resets the state too, so it masks every check but a_pd_defaults
default disable iff (srst_i || !power_down_n_i);

a_bus_wait: assert property ($rose(read_i || write_i) |-> waitrequest_o ##1 !waitrequest_o)
	else $error("bus answer not after one wait state");
a_ramp_step: assert property (
	attenuation_o - $past(attenuation_o) <= 13'h0008 ||
	$past(attenuation_o) - attenuation_o <= 13'h0008)
	else $error("attenuation jumped");
a_att_range: assert property (attenuation_o <= 13'h1FC0)
	else $error("attenuation above full scale");
a_gain_range: assert property (gain_left_o <= 5'h18 && gain_right_o <= 5'h18)
	else $error("analog gain index out of range");
a_alc_common: assert property (alc_active_o [*3] |-> gain_left_o == gain_right_o)
	else $error("channels differ under level control");
a_alc_pin: assert property (alc_pin_i [*8] |-> alc_active_o)
	else $error("level control pin ignored");
a_mute_down: assert property (soft_mute_pin_i [*5] |-> attenuation_o <= $past(attenuation_o))
	else $error("attenuation rose while muted");
a_serial_quiet: assert property ((!chip_select_n_i && !write_i) [*6] |-> $stable(input_select_o))
	else $error("register changed inside a frame");
a_pd_defaults: assert property (@(posedge clk_i) disable iff (srst_i)
	!power_down_n_i [*6] |-> input_select_o == 3'h0 && power_enable_o && gain_left_o == 5'h00)
	else $error("power-down left a register set");

c_alc: cover property (alc_active_o);
c_muted: cover property (soft_mute_pin_i && attenuation_o == 13'h0000);
c_frame: cover property ($rose(chip_select_n_i));
endmodule

bind adc_gain_alc_mute_ctrl adc_gain_props chk_u (
	.clk_i, .srst_i, .read_i, .write_i, .waitrequest_o, .chip_select_n_i, .power_down_n_i,
	.alc_pin_i, .soft_mute_pin_i, .gain_left_o, .gain_right_o, .attenuation_o,
	.input_select_o, .power_enable_o, .alc_active_o
);

// File: tb/three_wire_host.sv
// Behavioural host that writes frames on the three-wire control port.
// Assumes the bench calls send; the link clock only runs inside frames.
`timescale 1ns/100ps
module three_wire_host #(
	parameter HALF_NS = 80
) (
	// Three-wire pins
	output reg chip_select_n_o,
	output reg control_clock_o,
	output reg control_data_o
);
////////////////////////////////////////////////////////////////////////////////
initial begin
	chip_select_n_o = 1'b1;
	control_clock_o = 1'b1;
	control_data_o = 1'b0;
end

task send(input logic [15:0] frame, input integer nbits);
	integer i;
	begin
		#17;
		chip_select_n_o = 1'b0;
		for (i = 15; i > 15 - nbits; i = i - 1) begin
			control_clock_o = 1'b0;
			control_data_o = frame[i];
			#HALF_NS;
			control_clock_o = 1'b1;
			#HALF_NS;
		end
		chip_select_n_o = 1'b1;
		// Flip after release so a stale bit never looks valid
		control_data_o = ~control_data_o;
		#(4 * HALF_NS);
	end
endtask
endmodule
